/* rtl/cam_logic_pkg.sv */
package cam_logic_pkg;

   localparam int CLK_HZ          = 50_000_000;
   localparam int CYCLE_TIME_US   = 1000;
   localparam int CYCLE_CLKS      = CYCLE_TIME_US * (CLK_HZ / 1_000_000);
   localparam int SWITCH_OFF_DELAY_UNIT_MS    = 1;
   localparam int SWITCH_OFF_DELAY_UNIT_CLKS  = SWITCH_OFF_DELAY_UNIT_MS * (CLK_HZ / 1000);
   localparam int RESPONSE_MAX_US = 1500;
   localparam int N_ENTRIES       = 32;
   localparam int N_SWITCH_OFF_DELAY          = 8;

   localparam logic [7:0] ADR_CTRL      = 8'h00;
   localparam logic [7:0] ADR_STATUS    = 8'h04;
   localparam logic [7:0] ADR_IN_MAP    = 8'h08;
   localparam logic [7:0] ADR_OUT_MAP   = 8'h0C;
   localparam logic [7:0] ADR_SWITCH_OFF_DELAY_EDGE = 8'h10;
   localparam logic [7:0] ADR_SWITCH_OFF_DELAY_T0   = 8'h14;
   localparam logic [7:0] ADR_SWITCH_OFF_DELAY_T1   = 8'h18;
   localparam logic [7:0] ADR_PROG_ADR  = 8'h1C;
   localparam logic [7:0] ADR_PROG_LO   = 8'h20;
   localparam logic [7:0] ADR_PROG_HI   = 8'h24;
   localparam logic [7:0] ADR_RESULTS   = 8'h28;
   localparam logic [7:0] ADR_SHREG     = 8'h2C;

   localparam logic [31:0] CTRL_RST     = 32'h0000_0100;
   localparam logic [31:0] IN_MAP_RST   = 32'h0000_5604;
   localparam logic [31:0] OUT_MAP_RST  = 32'h0000_3210;
   localparam int          CTRL_LOGIC   = 0;
   localparam int          CTRL_INCR    = 1;
   localparam int          CTRL_MON     = 2;
   localparam int          CTRL_NIN_LSB = 4;

   localparam logic [7:0]  ERR_NONE     = 8'h00;
   localparam logic [7:0]  ERR_NO_ENC   = 8'h64;
   localparam logic [7:0]  ERR_MONITOR  = 8'h69;
   localparam logic [15:0] MON_LIMIT    = 16'h0003;
   localparam logic [3:0]  MON_PERIODS  = 4'h8;
   localparam logic [1:0]  PD_WORDS     = 2'h2;
   // Arbitrary neutral identification value
   localparam logic [7:0]  FIELDBUS_ID  = 8'h5A;

   localparam int SHREG_CLR_BIT   = 31;
   localparam int SHREG_DATA_BIT  = 30;
   localparam int SHREG_PULSE_BIT = 29;

   typedef enum logic [1:0] {OP_AND, OP_OR, OP_NAND, OP_NOR} logic_op_t;

   typedef struct packed {
      logic       inv;
      logic [2:0] src;
      logic [4:0] idx;
   } opnd_t;

   typedef struct packed {
      logic [1:0]      nops;
      logic_op_t [2:0] ops;
      opnd_t [3:0]     opnd;
   } prog_entry_t;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } wb_req_t;

endpackage

/* rtl/prog_mem.sv */
`timescale 1ns/1ns
module prog_mem
   import cam_logic_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        we_i,
   input  wire logic [4:0]  waddr_i,
   input  wire prog_entry_t wdata_i,
   input  wire logic [4:0]  raddr_i,
   output prog_entry_t      rdata_o
);

   prog_entry_t mem [N_ENTRIES];

   always_ff @(posedge clk_i)
   begin
      if (we_i)
      begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
   end

endmodule // prog_mem

/* rtl/switch_off_delay_timer.sv */
`timescale 1ns/1ns
module switch_off_delay_timer
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       unit_tick_i,
   input  wire logic       trigger_i,
   input  wire logic [7:0] delay_i,
   output logic            hold_o
);

   logic [7:0] count;

   // Every trigger reloads, so the delay restarts
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         count <= 8'h00;
      else if (trigger_i)
         count <= delay_i;
      else if (unit_tick_i && count != 8'h00)
         count <= count - 8'h01;
   end

   assign hold_o = (count != 8'h00);

endmodule // switch_off_delay_timer

/* rtl/cam_output_logic_engine.sv */
// Behaviour
// - Encoder jumps over three for eight cycles: error 105
// - Missing absolute encoder always reports error 100
// - Quadrature tracks A and B update count
// - Inputs 3 and 4 clear incremental count
// - Four process bytes each way, two words
// - Input bytes mapped: program, logic inputs
// - Output bytes mapped: position, outputs, speed, error
// - Fixed fieldbus identity and two-word width
// - Up to four operands, three AND/OR/NAND/NOR
// - Operands: inputs, cams, markers, outputs, shift register
// - Any operand may be inverted
// - Inputs 1-4 pins (1-2 with incremental encoder), 5-16 bus, count selectable
// - Unprogrammed outputs and markers follow cam tracks
// - Evaluation strictly left to right
// - Outputs 1-8 retriggerable switch-off delay 0-255 ms
// - Running delay holds output active
// - Clear flag high clears shift register
// - Pulse flag rising edge shifts in data flag
// - Result within 1.5 ms of input change
`timescale 1ns/1ns
module cam_output_logic_engine
   import cam_logic_pkg::*;
#(
   parameter int CYCLE_CLK = CYCLE_CLKS,
   parameter int UNIT_CLK  = SWITCH_OFF_DELAY_UNIT_CLKS
)
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic [3:0]  hw_in_i,
   input  wire logic        track_a_i,
   input  wire logic        track_b_i,
   input  wire logic [15:0] ssi_pos_i,
   input  wire logic        enc_fault_i,
   input  wire logic [15:0] cam_i,
   input  wire logic [31:0] pd_in_i,
   output logic [31:0]      pd_out_o,
   output logic [7:0]       fieldbus_id_o,
   output logic [1:0]       pd_words_o,
   output logic [7:0]       program_o,
   output logic [15:0]      hw_out_o
);

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
         if (sel[b])
            r[b*8 +: 8] = nw[b*8 +: 8];
      return r;
   endfunction

   function automatic logic [7:0] pick(input logic [31:0] v, input logic [1:0] sel);
      return v[sel*8 +: 8];
   endfunction

   function automatic logic fetch(input opnd_t o, input logic [15:0] lin, input logic [15:0] cam,
                                  input logic [15:0] mrk, input logic [15:0] outs, input logic [31:0] sh);
      logic v;
      v = 1'b0;
      unique case (o.src)
         3'h0: v = lin[o.idx[3:0]];
         3'h1: v = cam[o.idx[3:0]];
         3'h2: v = mrk[o.idx[3:0]];
         3'h3: v = outs[o.idx[3:0]];
         3'h4: v = sh[o.idx];
         default: v = 1'b0;
      endcase
      return v ^ o.inv;
   endfunction

   function automatic logic apply(input logic_op_t op, input logic a, input logic b);
      logic r;
      r = 1'b0;
      unique case (op)
         OP_AND:  r = a & b;
         OP_OR:   r = a | b;
         OP_NAND: r = ~(a & b);
         OP_NOR:  r = ~(a | b);
      endcase
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Register bus

   wb_req_t     req;
   logic [31:0] ctrl;
   logic [31:0] in_map;
   logic [31:0] out_map;
   logic [7:0]  switch_off_delay_edge;
   logic [63:0] switch_off_delay_time;
   logic [4:0]  prog_adr;
   logic [26:0] prog_lo;
   logic [31:0] prog_valid;
   logic [7:0]  error_code;
   logic [15:0] position;
   logic [31:0] logic_res;
   logic [31:0] shreg;

   assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};

   wire         wb_hit  = req.cyc & req.stb & ~wb_ack_o;
   wire         wb_wr   = wb_hit & req.we;
   wire         wr_ctrl = wb_wr && req.adr == ADR_CTRL;
   wire         wr_stat = wb_wr && req.adr == ADR_STATUS;
   wire         wr_prog = wb_wr && req.adr == ADR_PROG_HI;
   wire [31:0]  rd_data =
      req.adr == ADR_CTRL      ? ctrl :
      req.adr == ADR_STATUS    ? {position, 8'h00, error_code} :
      req.adr == ADR_IN_MAP    ? in_map :
      req.adr == ADR_OUT_MAP   ? out_map :
      req.adr == ADR_SWITCH_OFF_DELAY_EDGE ? {24'h00_0000, switch_off_delay_edge} :
      req.adr == ADR_SWITCH_OFF_DELAY_T0   ? switch_off_delay_time[31:0] :
      req.adr == ADR_SWITCH_OFF_DELAY_T1   ? switch_off_delay_time[63:32] :
      req.adr == ADR_PROG_ADR  ? {27'h000_0000, prog_adr} :
      req.adr == ADR_PROG_LO   ? {5'h00, prog_lo} :
      req.adr == ADR_RESULTS   ? logic_res :
      req.adr == ADR_SHREG     ? shreg : 32'h0000_0000;
   wire [31:0]  wr_val  = merge(rd_data, req.dat, req.sel);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= wb_hit;
         wb_dat_o <= rd_data;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl       <= CTRL_RST;
         in_map     <= IN_MAP_RST;
         out_map    <= OUT_MAP_RST;
         switch_off_delay_edge  <= 8'hFF;
         switch_off_delay_time  <= 64'h0000_0000_0000_0000;
         prog_adr   <= 5'h00;
         prog_lo    <= 27'h000_0000;
         prog_valid <= 32'h0000_0000;
      end
      else if (wb_wr)
      begin
         if (wr_ctrl)
            ctrl <= wr_val;
         if (req.adr == ADR_IN_MAP)
            in_map <= wr_val;
         if (req.adr == ADR_OUT_MAP)
            out_map <= wr_val;
         if (req.adr == ADR_SWITCH_OFF_DELAY_EDGE)
            switch_off_delay_edge <= wr_val[7:0];
         if (req.adr == ADR_SWITCH_OFF_DELAY_T0)
            switch_off_delay_time[31:0] <= wr_val;
         if (req.adr == ADR_SWITCH_OFF_DELAY_T1)
            switch_off_delay_time[63:32] <= wr_val;
         if (req.adr == ADR_PROG_ADR)
            prog_adr <= wr_val[4:0];
         if (req.adr == ADR_PROG_LO)
            prog_lo <= wr_val[26:0];
         if (wr_prog)
            prog_valid[prog_adr] <= wr_val[18];
      end
   end

   wire logic_en = ctrl[CTRL_LOGIC];
   wire incr_en  = ctrl[CTRL_INCR];
   wire mon_en   = ctrl[CTRL_MON];
   wire [4:0] n_inputs = ctrl[CTRL_NIN_LSB +: 5];

   ////////////////////////////////////////////////////////////////////////////////
   // Fieldbus process data

   wire [7:0]  prog_byte  = pick(pd_in_i, in_map[1:0]);
   wire [7:0]  ack_byte   = in_map[6] ? pick(pd_in_i, in_map[5:4]) : 8'h00;
   wire [7:0]  lin_lo     = in_map[10] ? pick(pd_in_i, in_map[9:8]) : 8'h00;
   wire [7:0]  lin_hi     = in_map[14] ? pick(pd_in_i, in_map[13:12]) : 8'h00;
   // pins give inputs 1-4 (only 1-2 with incremental encoder, 3-4 read zero), bus gives 5-16, unused inputs read zero
   wire [3:0]  pin_in     = incr_en ? {2'b00, hw_in_i[1:0]} : hw_in_i;
   wire [15:0] lin_all    = {lin_hi, lin_lo[7:4], pin_in};
   wire [15:0] lin_mask   = 16'(17'h1_FFFF >> (5'h11 - {1'b0, n_inputs}));
   wire [15:0] logic_in   = lin_all & lin_mask;

   logic [15:0] speed;
   logic [7:0]  ack_prev;
   wire  [63:0] out_src = {error_code, program_o, speed[7:0], speed[15:8],
                           logic_res[7:0], logic_res[15:8], position[7:0], position[15:8]};

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pd_out_o  <= 32'h0000_0000;
         program_o <= 8'h00;
         ack_prev  <= 8'h00;
      end
      else
      begin
         for (int b = 0; b < 4; b++)
            pd_out_o[b*8 +: 8] <= out_src[out_map[b*4 +: 3]*8 +: 8];
         if (in_map[2])
            program_o <= prog_byte;
         ack_prev <= ack_byte;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         fieldbus_id_o <= FIELDBUS_ID;
         pd_words_o    <= PD_WORDS;
      end
      else
      begin
         fieldbus_id_o <= FIELDBUS_ID;
         pd_words_o    <= PD_WORDS;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Encoder

   logic [1:0]  quad_prev;
   logic [15:0] inc_count;
   wire  [1:0]  quad_now = {track_a_i, track_b_i};
   // Clr+ on input 3 high with Clr- on input 4 low
   wire         clr_pair = hw_in_i[2] & ~hw_in_i[3];
   wire         step_up  = {quad_prev, quad_now} inside {4'b0010, 4'b1011, 4'b1101, 4'b0100};
   wire         step_dn  = {quad_prev, quad_now} inside {4'b0001, 4'b0111, 4'b1110, 4'b1000};

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         quad_prev <= 2'b00;
         inc_count <= 16'h0000;
      end
      else
      begin
         quad_prev <= quad_now;
         if (incr_en && clr_pair)
            inc_count <= 16'h0000;
         else if (incr_en && step_up)
            inc_count <= inc_count + 16'h0001;
         else if (incr_en && step_dn)
            inc_count <= inc_count - 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Cycle and delay time bases

   logic [31:0] cyc_cnt;
   logic [31:0] unit_cnt;
   wire         cycle_tick = (cyc_cnt == 32'(CYCLE_CLK - 1));
   wire         unit_tick  = (unit_cnt == 32'(UNIT_CLK - 1));

   always_ff @(posedge clk_i)
   begin
      if (rst_i || cycle_tick)
         cyc_cnt <= 32'h0000_0000;
      else
         cyc_cnt <= cyc_cnt + 32'h0000_0001;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i || unit_tick)
         unit_cnt <= 32'h0000_0000;
      else
         unit_cnt <= unit_cnt + 32'h0000_0001;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Logic scan

   typedef enum logic [1:0] {S_IDLE, S_READ, S_EVAL, S_COMMIT} scan_state_t;
   scan_state_t state;
   logic [4:0]  idx;
   logic [15:0] snap_in;
   logic [15:0] snap_cam;
   logic [31:0] res_new;
   prog_entry_t entry;

   prog_mem u_prog_mem
   (
      .clk_i   (clk_i),
      .we_i    (wr_prog),
      .waddr_i (prog_adr),
      .wdata_i (prog_entry_t'({wr_val[16:0], prog_lo})),
      .raddr_i (idx),
      .rdata_o (entry)
   );

   wire [3:0] opv;
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_opnd
         assign opv[g] = fetch(entry.opnd[g], snap_in, snap_cam, logic_res[31:16], logic_res[15:0], shreg);
      end
   endgenerate

   // accumulate left to right, no precedence
   wire acc1 = (entry.nops > 2'h0) ? apply(entry.ops[0], opv[0], opv[1]) : opv[0];
   wire acc2 = (entry.nops > 2'h1) ? apply(entry.ops[1], acc1, opv[2]) : acc1;
   wire acc3 = (entry.nops > 2'h2) ? apply(entry.ops[2], acc2, opv[3]) : acc2;
   // unprogrammed entry follows its cam track
   wire entry_res = (logic_en && prog_valid[idx]) ? acc3 : snap_cam[idx[3:0]];

   wire commit = (state == S_COMMIT);

   // scan starts every cycle and ends well inside the bound
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state <= S_IDLE;
         idx   <= 5'h00;
      end
      else
      begin
         unique case (state)
            S_IDLE:   if (cycle_tick) state <= S_READ;
            S_READ:   state <= S_EVAL;
            S_EVAL:   state <= (idx == 5'h1F) ? S_COMMIT : S_READ;
            S_COMMIT: state <= S_IDLE;
         endcase
         if (state == S_EVAL)
            idx <= idx + 5'h01;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         snap_in  <= 16'h0000;
         snap_cam <= 16'h0000;
         res_new  <= 32'h0000_0000;
      end
      else
      begin
         // inputs sampled once per controller cycle
         if (state == S_IDLE && cycle_tick)
         begin
            snap_in  <= logic_in;
            snap_cam <= cam_i;
         end
         if (state == S_EVAL)
            res_new[idx] <= entry_res;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Commit: results, shift register, switch-off delays

   wire shreg_clear_flag = res_new[SHREG_CLR_BIT];
   wire shreg_data_flag  = res_new[SHREG_DATA_BIT];
   wire shreg_pulse_flag = res_new[SHREG_PULSE_BIT];
   wire shreg_pulse_rise = shreg_pulse_flag & ~logic_res[SHREG_PULSE_BIT];

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         logic_res <= 32'h0000_0000;
         shreg     <= 32'h0000_0000;
      end
      else if (commit)
      begin
         logic_res <= res_new;
         if (shreg_clear_flag)
            shreg <= 32'h0000_0000;
         // shift up, new bit at zero
         else if (shreg_pulse_rise)
            shreg <= {shreg[30:0], shreg_data_flag};
      end
   end

   wire [7:0] hold;
   generate
      for (g = 0; g < N_SWITCH_OFF_DELAY; g++)
      begin : g_switch_off_delay
         // trigger on the selected edge of the logic result
         wire trig = commit && (switch_off_delay_edge[g] ? (res_new[g] & ~logic_res[g]) : (~res_new[g] & logic_res[g]));
         switch_off_delay_timer u_switch_off_delay
         (
            .clk_i       (clk_i),
            .rst_i       (rst_i),
            .unit_tick_i (unit_tick),
            .trigger_i   (trig),
            .delay_i     (switch_off_delay_time[g*8 +: 8]),
            .hold_o      (hold[g])
         );
      end
   endgenerate

   // running delay keeps the output on
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         hw_out_o <= 16'h0000;
      else
         hw_out_o <= logic_res[15:0] | {8'h00, hold};
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Encoder monitoring and errors

   logic [15:0] prev_pos;
   logic [3:0]  mon_cnt;
   wire  [15:0] pos_now  = incr_en ? inc_count : ssi_pos_i;
   wire  [15:0] delta    = pos_now - prev_pos;
   wire  [15:0] delta_ab = delta[15] ? 16'(~delta + 16'h0001) : delta;
   wire         deviates = delta_ab > MON_LIMIT;
   wire         mon_trip = commit && mon_en && deviates && (mon_cnt == MON_PERIODS - 4'h1);
   wire         enc_miss = commit && !incr_en && enc_fault_i;
   wire         err_ack  = wr_stat || (ack_byte != 8'h00 && ack_prev == 8'h00);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         prev_pos <= 16'h0000;
         position <= 16'h0000;
         speed    <= 16'h0000;
         mon_cnt  <= 4'h0;
      end
      else if (commit)
      begin
         prev_pos <= pos_now;
         position <= pos_now;
         speed    <= delta;
         mon_cnt  <= (mon_en && deviates && mon_cnt != MON_PERIODS) ? mon_cnt + 4'h1 : 4'h0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         error_code <= ERR_NONE;
      // missing absolute encoder reported every cycle, never suppressed
      else if (enc_miss)
         error_code <= ERR_NO_ENC;
      // persistent deviation raises the monitor error
      else if (mon_trip)
         error_code <= ERR_MONITOR;
      else if (err_ack)
         error_code <= ERR_NONE;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   bus_ack_next_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_hit |=> wb_ack_o ##1 !wb_ack_o) else $error("bus ack not one cycle after request");

   monitor_error_a: assert property (@(posedge clk_i) disable iff (rst_i)
      mon_trip && !enc_miss |=> error_code == ERR_MONITOR) else $error("monitor error not raised");

   missing_enc_a: assert property (@(posedge clk_i) disable iff (rst_i)
      enc_miss |=> error_code == ERR_NO_ENC) else $error("missing encoder error suppressed");

   quad_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
      incr_en && !clr_pair && step_up |=> inc_count == $past(inc_count) + 16'h0001) else $error("quadrature step lost");

   count_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      incr_en && clr_pair |=> inc_count == 16'h0000) else $error("clear pair did not clear count");

   follow_cam_a: assert property (@(posedge clk_i) disable iff (rst_i)
      commit && !logic_en |=> logic_res == {2{$past(snap_cam)}}) else $error("results do not follow cams");

   shreg_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      commit && shreg_clear_flag |=> shreg == 32'h0000_0000) else $error("shift register not cleared");

   shreg_shift_a: assert property (@(posedge clk_i) disable iff (rst_i)
      commit && !shreg_clear_flag && shreg_pulse_rise
      |=> shreg == {$past(shreg[30:0]), $past(shreg_data_flag)}) else $error("shift register did not shift");

   delay_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 ((hw_out_o[7:0] & $past(hold)) == $past(hold))) else $error("output dropped during delay");

   scan_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
      state == S_IDLE && cycle_tick |-> ##65 commit) else $error("scan did not finish in time");

   cover_shift_c: cover property (@(posedge clk_i) disable iff (rst_i) commit && shreg_pulse_rise);
   cover_trip_c:  cover property (@(posedge clk_i) disable iff (rst_i) mon_trip);
   cover_hold_c:  cover property (@(posedge clk_i) disable iff (rst_i) hold[0] && !logic_res[0]);

endmodule // cam_output_logic_engine

/* tb/enc_model.sv */
`timescale 1ns/1ns
module enc_model
#(
   parameter int STEP_CLK = 40
)
(
   input  wire logic       clk_i,
   input  wire logic [7:0] jump_i,
   input  wire logic       quad_i,
   output logic [15:0]     ssi_pos_o,
   output logic            track_a_o,
   output logic            track_b_o
);
   int          cnt = 0;
   logic [1:0]  phase = 2'h0;
   logic [15:0] pos = 16'h0000;
   always @(posedge clk_i)
   begin
      cnt <= (cnt == STEP_CLK - 1) ? 0 : cnt + 1;
      if (cnt == 0)
      begin
         pos <= pos + 16'(jump_i);
         phase <= phase + 2'(quad_i);
      end
   end
   assign ssi_pos_o = pos;
   assign track_a_o = phase[0] ^ phase[1];
   assign track_b_o = phase[1];
endmodule // enc_model

/* tb/cam_output_logic_engine_tb.sv */
`timescale 1ns/1ns
module cam_output_logic_engine_tb;
   import cam_logic_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   wb_req_t     req = '0;
   logic [31:0] rdat, wb_dat_o, pd_out_o;
   logic [31:0] pd_in = '0;
   logic        wb_ack_o, trk_a, trk_b;
   logic        quad = 1'b0;
   logic        fault = 1'b0;
   logic [3:0]  hw_in = '0;
   logic [3:0]  op_tab = 4'h6;
   logic [15:0] cam = '0;
   logic [15:0] ssi_pos, hw_out_o;
   logic [7:0]  jump = '0;
   logic [7:0]  fieldbus_id_o, program_o;
   logic [1:0]  pd_words_o;
   int          mismatches = 0;
   int          checks_done = 0;
   logic [15:0] sh_cam [7] = '{16'h4000, 16'h6000, 16'h0000, 16'h2000, 16'h0000, 16'h6000, 16'h8000};
   logic [31:0] sh_exp [7] = '{32'h0, 32'h1, 32'h1, 32'h2, 32'h2, 32'h5, 32'h0};

   cam_output_logic_engine #(.CYCLE_CLK(100), .UNIT_CLK(20)) i_cam_output_logic_engine
   (
      .clk_i, .rst_i, .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we), .wb_adr_i(req.adr),
      .wb_sel_i(req.sel), .wb_dat_i(req.dat), .wb_dat_o, .wb_ack_o, .hw_in_i(hw_in), .track_a_i(trk_a),
      .track_b_i(trk_b), .ssi_pos_i(ssi_pos), .enc_fault_i(fault), .cam_i(cam), .pd_in_i(pd_in),
      .pd_out_o, .fieldbus_id_o, .pd_words_o, .program_o, .hw_out_o
   );
   enc_model #(.STEP_CLK(40)) i_enc_model
   (
      .clk_i, .jump_i(jump), .quad_i(quad), .ssi_pos_o(ssi_pos), .track_a_o(trk_a), .track_b_o(trk_b)
   );

   initial
   begin
      forever #10 clk_i = ~clk_i;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic results();
      if (mismatches == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      req <= '{1'b1, 1'b1, w, a, 4'hF, d};
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1)
      begin
         mismatches++;
         results();
      end
      rdat = wb_dat_o;
      req <= '0;
      @(posedge clk_i);
   endtask

   task automatic prog(input logic [4:0] e, input logic [31:0] lo, input logic [31:0] hi);
      bus(1'b1, ADR_PROG_ADR, 32'(e));
      bus(1'b1, ADR_PROG_LO, lo);
      bus(1'b1, ADR_PROG_HI, hi);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      wt(3);
      rst_i <= 1'b0;
      wt(1);
      chk("words", 32'h2, 32'(pd_words_o));
      chk("ident", 32'(FIELDBUS_ID), 32'(fieldbus_id_o));
      bus(1'b0, 8'h3C, 32'h0);
      chk("unmapped", 32'h0, rdat);
      cam <= 16'hA5C3;
      pd_in <= 32'h0000_0007;
      wt(250);
      chk("follow", 32'h0000_A5C3, 32'(hw_out_o));
      chk("pd_out", 32'hC3A5_0000, pd_out_o);
      chk("program", 32'h7, 32'(program_o));
      bus(1'b1, ADR_CTRL, 32'h0000_0101);
      prog(5'h01, 32'h0488_4220, 32'h0005_0200);
      cam <= 16'h0001;
      for (int op = 0; op < 4; op++)
      begin
         prog(5'h00, 32'h0000_4220, 32'h0004_8000 | (32'(op) << 9));
         wt(250);
         chk("ops", {30'h0, 1'b1, op_tab[op]}, 32'(hw_out_o[1:0]));
      end
      cam <= 16'h0005;
      wt(250);
      chk("order", 32'h0, 32'(hw_out_o[1:0]));
      for (int i = 0; i < 7; i++)
      begin
         cam <= sh_cam[i];
         wt(250);
         bus(1'b0, ADR_SHREG, 32'h0);
         chk("shreg", sh_exp[i], rdat);
      end
      bus(1'b1, ADR_SWITCH_OFF_DELAY_T0, 32'h0014_0000);
      cam <= 16'h0004;
      wt(150);
      cam <= 16'h0000;
      wt(250);
      chk("hold", 32'h1, 32'(hw_out_o[2]));
      wt(400);
      chk("release", 32'h0, 32'(hw_out_o[2]));
      fault <= 1'b1;
      wt(250);
      bus(1'b0, ADR_STATUS, 32'h0);
      chk("no_enc", 32'h64, 32'(rdat[7:0]));
      fault <= 1'b0;
      bus(1'b1, ADR_STATUS, 32'h0);
      bus(1'b1, ADR_CTRL, 32'h0000_0105);
      jump <= 8'h08;
      wt(500);
      bus(1'b0, ADR_STATUS, 32'h0);
      chk("mon_early", 32'h0, 32'(rdat[7:0]));
      wt(700);
      bus(1'b0, ADR_STATUS, 32'h0);
      chk("mon", 32'h69, 32'(rdat[7:0]));
      jump <= 8'h00;
      bus(1'b1, ADR_CTRL, 32'h0000_0103);
      quad <= 1'b1;
      wt(400);
      quad <= 1'b0;
      hw_in <= 4'h4;
      wt(250);
      hw_in <= 4'h0;
      quad <= 1'b1;
      wt(160);
      quad <= 1'b0;
      wt(250);
      bus(1'b0, ADR_STATUS, 32'h0);
      chk("count", 32'h4, 32'(rdat[31:16]));
      bus(1'b1, ADR_IN_MAP, 32'h0000_5674);
      prog(5'h09, 32'h0000_0004, 32'h0004_0000);
      pd_in <= 32'h0110_0007;
      wt(250);
      chk("lin5", 32'h1, 32'(hw_out_o[9]));
      bus(1'b0, ADR_STATUS, 32'h0);
      chk("err_ack", 32'h0, 32'(rdat[7:0]));
      bus(1'b1, ADR_CTRL, 32'h0000_0043);
      wt(250);
      chk("lin_cut", 32'h0, 32'(hw_out_o[9]));
      results();
   end
endmodule // cam_output_logic_engine_tb
